// *** testbench/clock_source_model.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "input_select_defines.vh"
module clock_source_model (
	// Clock and loop state
	input wire logic mclk_in,
	input wire logic [3:0] mode_out, active_input_out,
	// Scenario controls
	input wire logic [3:0] valid_set,
	input wire logic [7:0] lock_dly,
	// Toward the block
	output logic [3:0] input_valid_in,
	output logic loop_locked_in,
	output logic [31:0] measured_freq_in = 32'h0
);
	logic [7:0] cnt_r = 8'h00;
	logic [3:0] last_r = 4'h0;
	assign input_valid_in = valid_set;
	assign loop_locked_in = cnt_r >= lock_dly && active_input_out != 4'h0;
	// Lock detector, restarts pull-in on any input change
	always @(posedge mclk_in) begin
		last_r <= active_input_out;
		if (mode_out[0] || mode_out[3] || active_input_out != last_r)
			cnt_r <= 8'h00;
		else if (cnt_r != 8'hff)
			cnt_r <= cnt_r + 8'h01;
	end
	// Frequency word per source, scrambles when none selected
	always @(posedge mclk_in)
		measured_freq_in <= active_input_out == 4'h0 ? ~measured_freq_in : {28'h0100000, active_input_out};
endmodule // clock_source_model
`default_nettype wire

// *** testbench/input_select_holdover_ctrl_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "input_select_defines.vh"
module select_rules_check #(parameter NUM_DIV = 4) (
	// Clock, reset and bus
	input wire logic mclk_in, reset_in, avs_read_in, avs_write_in, avs_waitrequest_out,
	// Host pins and loop status
	input wire logic freq_step_up_in, init_done_in,
	input wire logic [3:0] input_valid_in, active_input_out, mode_out,
	// Loop control outputs
	input wire logic loss_of_lock_flag_out, fast_bw_out, loop_freq_hold_out,
	input wire logic ext_ref_out, xtal_cap_en_out,
	input wire logic [9:0] ref_trim_out,
	input wire logic [NUM_DIV*32-1:0] divider_freq_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (reset_in);
	// -------------------------
	// Assertions
	// -------------------------
	a_bus_answer: assert property ((avs_read_in || avs_write_in) |-> ##[0:2] !avs_waitrequest_out)
		else $error("bus request not answered");
	a_wait_single: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
		else $error("waitrequest low too long");
	a_lock_report: assert property ((mode_out == `MODE_LOCK) [*2] |-> !loss_of_lock_flag_out)
		else $error("lock not reported");
	a_lost_input: assert property ((mode_out == `MODE_LOCK && input_valid_in == 4'h0)
		|-> ##[1:4] (mode_out == `MODE_HOLD || mode_out == `MODE_FREE))
		else $error("no holdover after inputs lost");
	a_hold_flag: assert property ((mode_out == `MODE_HOLD) [*2] |-> loop_freq_hold_out)
		else $error("holdover frequency not applied");
	a_cap_off: assert property (xtal_cap_en_out == !ext_ref_out)
		else $error("load caps wrong for reference");
	a_trim_span: assert property (ref_trim_out <= `TRIM_MAX_PPM)
		else $error("trim beyond span");
	a_step_refuse: assert property ($rose(freq_step_up_in) && mode_out == `MODE_HOLD
		|=> $stable(divider_freq_out) [*3])
		else $error("step taken in holdover");
	a_mode_onehot: assert property ($onehot(mode_out) && $onehot0(active_input_out))
		else $error("mode or active input malformed");
	a_fast_acq: assert property (fast_bw_out |-> (mode_out == `MODE_ACQ
		|| $past(mode_out) == `MODE_ACQ))
		else $error("fast bandwidth outside acquire");
	a_init_free: assert property (!init_done_in |-> mode_out == `MODE_FREE)
		else $error("left free-run before init");
	// Main scenarios
	c_hold: cover property (mode_out == `MODE_HOLD);
	c_lock: cover property (mode_out == `MODE_LOCK);
	c_step: cover property ($rose(freq_step_up_in) && mode_out == `MODE_LOCK);
endmodule // select_rules_check
bind input_select_holdover_ctrl select_rules_check #(.NUM_DIV(NUM_DIV)) rules_i (.*);
`default_nettype wire

// *** testbench/input_select_holdover_ctrl_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "input_select_defines.vh"
module input_select_holdover_ctrl_tb;
	logic mclk_in = 1'b0, reset_in = 1'b1, avs_read_in = 1'b0, avs_write_in = 1'b0;
	logic freq_step_up_in = 1'b0, freq_step_down_in = 1'b0, init_done_in = 1'b0;
	logic avs_waitrequest_out, loop_locked_in, loss_of_lock_flag_out, fast_bw_out, hitless_out;
	logic loop_freq_hold_out, ext_ref_out, xtal_cap_en_out, ref_trim_neg_out;
	logic [1:0] input_sel_in = 2'h0;
	logic [2:0] ref_div_out;
	logic [3:0] input_valid_in, active_input_out, mode_out, valid_set = 4'h0;
	logic [5:0] avs_address_in = 6'h00;
	logic [7:0] lock_dly = 8'h04;
	logic [9:0] ref_trim_out;
	logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, measured_freq_in, loop_freq_out, rd;
	logic [127:0] divider_freq_out;
	int fails = 0;
	int num_checks = 0;
	input_select_holdover_ctrl #(.SAMPLE_TICKS(32'd8)) dut (.*, .avs_byteenable_in(4'hf));
	clock_source_model src (.*);
	always #10 mclk_in = ~mclk_in;
	task chk(input logic [127:0] s, input logic [127:0] e);
		num_checks++;
		if (s !== e) begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task print_verdict;
		$display("checks=%0d fails=%0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Bus access held until waitrequest is seen low
	task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk_in);
		avs_read_in <= !w;
		avs_write_in <= w;
		avs_address_in <= a;
		avs_writedata_in <= d;
		do @(posedge mclk_in); while (avs_waitrequest_out !== 1'b0 && ++n < 20);
		chk(avs_waitrequest_out, 1'b0);
		rd = avs_readdata_out;
		avs_read_in <= 1'b0;
		avs_write_in <= 1'b0;
	endtask
	task wmode(input logic [3:0] m);
		int n;
		n = 0;
		while (mode_out !== m && n++ < 3000)
			@(negedge mclk_in);
		chk(mode_out, m);
	endtask
	task pulse(input logic dn);
		@(posedge mclk_in);
		freq_step_up_in <= !dn;
		freq_step_down_in <= dn;
		@(posedge mclk_in);
		freq_step_up_in <= 1'b0;
		freq_step_down_in <= 1'b0;
		repeat (4) @(negedge mclk_in);
	endtask
	task t_start;
		@(posedge mclk_in);
		valid_set <= 4'h1;
		repeat (20) @(negedge mclk_in);
		chk(mode_out, `MODE_FREE);
		chk(loss_of_lock_flag_out, 1'b1);
		chk(xtal_cap_en_out, 1'b1);
		bus(0, `REG_CTRL, 0);
		chk(rd, `CTRL_RESET);
		bus(0, `REG_PRIO, 0);
		chk(rd, 32'he4);
		init_done_in <= 1'b1;
		wmode(`MODE_ACQ);
		wmode(`MODE_LOCK);
		chk(loss_of_lock_flag_out, 1'b0);
		$display("start test done");
	endtask
	task t_manual;
		@(posedge mclk_in);
		valid_set <= 4'hf;
		for (int c = 0; c < 4; c++) begin
			@(posedge mclk_in);
			input_sel_in <= c[1:0];
			repeat (12) @(negedge mclk_in);
			wmode(`MODE_LOCK);
			chk(active_input_out, 4'h1 << c);
			bus(0, `REG_STATUS, 0);
			chk(rd[6:0], {1'b1, c[1:0], 4'h4});
		end
		bus(1, `REG_CTRL, 32'h0000_f00a);
		repeat (4) @(negedge mclk_in);
		wmode(`MODE_LOCK);
		chk(active_input_out, 4'h4);
		bus(1, `REG_CTRL, 32'h0000_f020);
		repeat (8) @(negedge mclk_in);
		chk(active_input_out, 4'h0);
		chk(mode_out == `MODE_HOLD || mode_out == `MODE_FREE, 1'b1);
		@(posedge mclk_in);
		input_sel_in <= 2'h0;
		bus(1, `REG_CTRL, `CTRL_RESET);
		wmode(`MODE_LOCK);
		$display("manual test done");
	endtask
	task t_step;
		bus(1, `REG_STEP_WORD, 32'h5);
		bus(1, `REG_STEP_CMD, 32'h0000_0f00);
		pulse(0);
		chk(divider_freq_out, {4{32'h5}});
		bus(1, `REG_STEP_CMD, 32'h0000_0102);
		repeat (4) @(negedge mclk_in);
		chk(divider_freq_out, 0);
		pulse(0);
		chk(divider_freq_out, 128'h5);
		pulse(1);
		chk(divider_freq_out, 0);
		pulse(0);
		chk(divider_freq_out, 128'h5);
		$display("step test done");
	endtask
	task t_hold;
		bus(1, `REG_HOLD_WIN, 32'h0001_0003);
		repeat (600) @(negedge mclk_in);
		@(posedge mclk_in);
		valid_set <= 4'h0;
		wmode(`MODE_HOLD);
		repeat (8) @(negedge mclk_in);
		chk(loop_freq_hold_out, 1'b1);
		chk(loop_freq_out, 32'h0100_0001);
		bus(0, `REG_HOLD_FREQ, 0);
		chk(rd, 32'h0100_0001);
		pulse(0);
		chk(divider_freq_out, 128'h5);
		@(posedge mclk_in);
		valid_set <= 4'h1;
		wmode(`MODE_ACQ);
		chk(loss_of_lock_flag_out, 1'b1);
		wmode(`MODE_LOCK);
		$display("hold test done");
	endtask
	task t_auto;
		@(posedge mclk_in);
		lock_dly <= 8'h40;
		valid_set <= 4'h6;
		bus(1, `REG_CTRL, 32'h0000_f091);
		wmode(`MODE_ACQ);
		chk(fast_bw_out, 1'b1);
		wmode(`MODE_LOCK);
		chk(fast_bw_out, 1'b0);
		chk(active_input_out, 4'h2);
		@(posedge mclk_in);
		valid_set <= 4'h7;
		repeat (8) @(negedge mclk_in);
		chk(active_input_out, 4'h1);
		bus(1, `REG_CTRL, 32'h0000_f001);
		valid_set <= 4'h6;
		repeat (8) @(negedge mclk_in);
		chk(active_input_out, 4'h2);
		@(posedge mclk_in);
		valid_set <= 4'h7;
		repeat (8) @(negedge mclk_in);
		chk(active_input_out, 4'h2);
		bus(1, `REG_CTRL, 32'h0000_e011);
		repeat (8) @(negedge mclk_in);
		chk(active_input_out, 4'h2);
		$display("auto test done");
	endtask
	task t_ref;
		bus(1, `REG_CTRL, 32'h0f2c_f140);
		repeat (2) @(negedge mclk_in);
		chk(ext_ref_out, 1'b1);
		chk(xtal_cap_en_out, 1'b0);
		chk(ref_trim_out, `TRIM_MAX_PPM);
		chk(ref_trim_neg_out, 1'b1);
		chk(ref_div_out, 3'h3);
		chk(hitless_out, 1'b1);
		bus(1, 6'h07, 32'hffff_ffff);
		bus(0, 6'h07, 0);
		chk(rd, 0);
		$display("reference test done");
	endtask
	// Watchdog
	initial begin
		#1000000;
		fails++;
		print_verdict;
	end
	// Main sequence
	initial begin
		repeat (12) @(posedge mclk_in);
		reset_in <= 1'b0;
		t_start;
		t_manual;
		t_step;
		t_hold;
		t_auto;
		t_ref;
		print_verdict;
	end
endmodule // input_select_holdover_ctrl_tb
`default_nettype wire

// *** verilog/input_select_defines.vh ***
`ifndef INPUT_SELECT_DEFINES_VH
`define INPUT_SELECT_DEFINES_VH

// ----------------------------------------
// Register word offsets (byte address / 4)
// ----------------------------------------
`define REG_CTRL        4'h0
`define REG_PRIO        4'h1
`define REG_HOLD_WIN    4'h2
`define REG_STEP_WORD   4'h3
`define REG_STEP_CMD    4'h4
`define REG_STATUS      4'h5
`define REG_HOLD_FREQ   4'h6
`define REG_NCO_0       4'h8

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CTRL_AUTO       0
`define CTRL_REG_SEL    1
`define CTRL_SEL_LO     2
`define CTRL_SEL_HI     3
`define CTRL_REVERT     4
`define CTRL_ZDM        5
`define CTRL_HITLESS    6
`define CTRL_FASTLOCK   7
`define CTRL_EXT_REF    8
`define CTRL_EN_LO      12
`define CTRL_EN_HI      15
`define CTRL_TRIM_LO    16
`define CTRL_TRIM_HI    25
`define CTRL_PREF_LO    26
`define CTRL_PREF_HI    28
`define CTRL_RESET      32'h0000_f000

// ----------------------------------------
// Operating modes (one-hot)
// ----------------------------------------
`define MODE_FREE       4'h1
`define MODE_ACQ        4'h2
`define MODE_LOCK       4'h4
`define MODE_HOLD       4'h8

// ----------------------------------------
// Timing and ranges
// ----------------------------------------
`define HIST_SECONDS    120
`define TRIM_MAX_PPM    10'h0c8
`define CLK_HZ          50000000
`define PREF_MIN_MHZ    54

`endif

// *** verilog/input_select_holdover_ctrl.v ***
// Contract
// R1: Locked: follow input, report lock pin/bit
// R2: Chosen input invalid, none valid: holdover
// R3: Keep frequency history up to 120 s
// R4: Average programmable window, skip recent delay
// R5: Holdover steers to averaged frequency
// R6: Valid input in holdover: reacquire glitchlessly
// R7: Register picks crystal or external reference
// R8: Reference divider for references above 54 MHz
// R9: Reference trim spans plus/minus 200 ppm
// R10: Step up adds word, down subtracts
// R11: Steps hit any chosen divider set
// R12: Steps accepted only free-run or locked
// R13: Pins or register pick manual input
// R14: Codes map inputs; zero-delay reserves 11
// R15: Manual input dead: free-run or holdover
// R16: Auto picks valid inputs by priority
// R17: Revertive: always highest-priority valid input
// R18: Non-revertive: keep active while valid
// R19: Hitless switch absorbs phase when enabled
// R20: Raise loss-of-lock during pull-in, no runts
// R21: Any unused input can be disabled
// R22: Gapped input gives averaged gap-free output
// R23: Start in free-run after init
// R24: Auto acquire; fast-lock bandwidth first
// R25: Expose mode and active input
`timescale 1ns/1ps
`default_nettype none
`include "input_select_defines.vh"

module input_select_holdover_ctrl #(
	parameter        NUM_DIV      = 4,
	parameter        HIST_DEPTH   = 64,
	parameter        HIST_AW      = 6,
	parameter [31:0] SAMPLE_TICKS = 32'd93750000 // 1.875 s per sample, 64 samples = 120 s
) (
	// Clock and reset
	input  wire        mclk_in,
	input  wire        reset_in,
	// Avalon-MM slave
	input  wire [5:0]  avs_address_in,
	input  wire        avs_read_in,
	input  wire        avs_write_in,
	input  wire [31:0] avs_writedata_in,
	input  wire [3:0]  avs_byteenable_in,
	output reg  [31:0] avs_readdata_out,
	output reg         avs_waitrequest_out,
	// Host pins
	input  wire [1:0]  input_sel_in,
	input  wire        freq_step_up_in,
	input  wire        freq_step_down_in,
	// Input qualification and loop status
	input  wire [3:0]  input_valid_in,
	input  wire        loop_locked_in,
	input  wire [31:0] measured_freq_in,
	input  wire        init_done_in,
	// Loop control outputs
	output reg  [3:0]  active_input_out,
	output reg  [3:0]  mode_out,
	output reg         loss_of_lock_flag_out,
	output reg         fast_bw_out,
	output reg         hitless_out,
	output reg  [31:0] loop_freq_out,
	output reg         loop_freq_hold_out,
	output reg         ext_ref_out,
	output reg         xtal_cap_en_out,
	output reg  [2:0]  ref_div_out,
	output reg  [9:0]  ref_trim_out,
	output reg         ref_trim_neg_out,
	output reg  [NUM_DIV*32-1:0] divider_freq_out
);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg  [31:0] ctrl_r;
	reg  [7:0]  prio_r;        // two bits per input, lower value wins
	reg  [HIST_AW-1:0] win_r;  // window size minus one
	reg  [HIST_AW-1:0] dly_r;  // samples skipped before failure
	reg  [31:0] step_word_r;
	reg  [NUM_DIV-1:0] step_mask_r;
	reg  [NUM_DIV*32-1:0] div_r;
	reg  [3:0]  mode_r;
	reg  [1:0]  act_r;
	reg         act_ok_r;
	reg  [31:0] hist_r [0:HIST_DEPTH-1];
	reg  [HIST_AW-1:0] wptr_r;
	reg  [HIST_AW:0]   fill_r;
	reg  [31:0] tick_r;
	reg  [31:0] hold_freq_r;
	reg         up_d_r;
	reg         dn_d_r;
	reg         bus_done_r;

	// Averager state (one-hot)
	localparam AV_IDLE = 2'b01;
	localparam AV_SUM  = 2'b10;
	reg  [1:0]  av_state_r;
	reg  [HIST_AW-1:0] av_ptr_r;
	reg  [HIST_AW:0]   av_cnt_r;
	reg  [HIST_AW+31:0] av_sum_r;
	// Averaged word: window sum over window size.
	// Quotient never exceeds one sample word, so the low word is exact.
	// Divider is combinational; it is only read at the end of a sum.
	wire [HIST_AW:0]    av_div  = {1'b0, win_r} + 1'b1;
	wire [HIST_AW+31:0] av_quot = av_sum_r / av_div;

	integer i;

	// ----------------------------------------
	// Input selection
	// ----------------------------------------
	wire [3:0] en_inputs = ctrl_r[`CTRL_EN_HI:`CTRL_EN_LO];
	wire       zdm       = ctrl_r[`CTRL_ZDM];
	// Usable inputs: valid, enabled, not feedback
	wire [3:0] usable = input_valid_in & en_inputs & {~zdm, 3'b111}; // R14 R16 R21
	wire [1:0] man_sel = ctrl_r[`CTRL_REG_SEL] ? ctrl_r[`CTRL_SEL_HI:`CTRL_SEL_LO]
	                                           : input_sel_in; // R13
	wire       man_ok = usable[man_sel]; // R14 R15
	reg  [1:0] best;
	reg        best_ok;

	// Highest-priority usable input
	always @* begin
		best = 2'd0;
		best_ok = 1'b0;
		for (i = 0; i < 4; i = i + 1) begin
			if (usable[i] && (!best_ok || prio_r[2*i+:2] < prio_r[2*best+:2])) begin
				best = i[1:0];
				best_ok = 1'b1;
			end
		end
	end

	// Next active input
	reg  [1:0] sel_nxt;
	reg        sel_ok_nxt;
	always @* begin
		if (!ctrl_r[`CTRL_AUTO]) begin
			sel_nxt = man_sel;
			sel_ok_nxt = man_ok;
		end else if (!ctrl_r[`CTRL_REVERT] && act_ok_r && usable[act_r]) begin
			sel_nxt = act_r; // R18
			sel_ok_nxt = 1'b1;
		end else begin
			sel_nxt = best; // R16 R17
			sel_ok_nxt = best_ok;
		end
	end

	// ----------------------------------------
	// Mode machine
	// ----------------------------------------
	// Non-hitless switch drops back to acquire so lock loss shows.
	// Hitless switch stays locked; the loop absorbs the phase step.
	// Leaving acquire with no history falls to free-run, not holdover.
	wire switching = sel_ok_nxt && act_ok_r && (sel_nxt != act_r);
	reg  [3:0] mode_nxt;
	always @* begin
		mode_nxt = mode_r;
		case (mode_r)
			`MODE_FREE: if (sel_ok_nxt && init_done_in) mode_nxt = `MODE_ACQ; // R24
			`MODE_ACQ: begin
				if (!sel_ok_nxt)
					mode_nxt = (fill_r != 0) ? `MODE_HOLD : `MODE_FREE; // R15
				else if (loop_locked_in && !switching)
					mode_nxt = `MODE_LOCK;
			end
			`MODE_LOCK: begin
				if (!sel_ok_nxt)
					mode_nxt = `MODE_HOLD; // R2 R15
				else if (!loop_locked_in || (switching && !ctrl_r[`CTRL_HITLESS]))
					mode_nxt = `MODE_ACQ; // R20
			end
			`MODE_HOLD: if (sel_ok_nxt) mode_nxt = `MODE_ACQ; // R6
			default: mode_nxt = `MODE_FREE;
		endcase
	end

	// Mode and selection registers
	always @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			mode_r <= `MODE_FREE; // R23
			act_r <= 2'd0;
			act_ok_r <= 1'b0;
		end else begin
			mode_r <= mode_nxt;
			act_r <= sel_ok_nxt ? sel_nxt : act_r;
			act_ok_r <= sel_ok_nxt;
		end
	end

	// ----------------------------------------
	// Frequency history
	// ----------------------------------------
	// Sample measured frequency while locked
	// Sampling pauses outside lock, so stale pull-in data never enters.
	// Fill count saturates at depth; pointer wraps as a ring.
	always @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			tick_r <= 32'h0000_0000;
			wptr_r <= {HIST_AW{1'b0}};
			fill_r <= {(HIST_AW+1){1'b0}};
		end else if (mode_r == `MODE_LOCK) begin
			if (tick_r >= SAMPLE_TICKS - 32'h0000_0001) begin
				tick_r <= 32'h0000_0000;
				wptr_r <= wptr_r + 1'b1; // R3
				if (fill_r < HIST_DEPTH)
					fill_r <= fill_r + 1'b1;
			end else begin
				tick_r <= tick_r + 32'h0000_0001;
			end
		end
	end

	// History storage
	always @(posedge mclk_in) begin
		if (mode_r == `MODE_LOCK && tick_r >= SAMPLE_TICKS - 32'h0000_0001)
			hist_r[wptr_r] <= measured_freq_in; // R3 R22
	end

	// Averager over window, skipping the newest samples
	always @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			av_state_r <= AV_IDLE;
			av_ptr_r <= {HIST_AW{1'b0}};
			av_cnt_r <= {(HIST_AW+1){1'b0}};
			av_sum_r <= {(HIST_AW+32){1'b0}};
			hold_freq_r <= 32'h0000_0000;
		end else begin
			case (av_state_r)
				AV_IDLE: if (mode_r == `MODE_LOCK && mode_nxt == `MODE_HOLD && fill_r != 0) begin
					av_ptr_r <= wptr_r - 1'b1 - dly_r; // R4
					av_cnt_r <= {1'b0, win_r} + 1'b1;
					av_sum_r <= {(HIST_AW+32){1'b0}};
					av_state_r <= AV_SUM;
				end
				AV_SUM: begin
					if (av_cnt_r == 0) begin
						hold_freq_r <= av_quot[31:0]; // R4
						av_state_r <= AV_IDLE;
					end else begin
						av_sum_r <= av_sum_r + hist_r[av_ptr_r];
						av_ptr_r <= av_ptr_r - 1'b1;
						av_cnt_r <= av_cnt_r - 1'b1;
					end
				end
				default: av_state_r <= AV_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Frequency steps
	// ----------------------------------------
	// Pin commands act on rising edges only; a held pin steps once.
	// Up and down in the same cycle cancel each other.
	wire up_edge = freq_step_up_in & ~up_d_r;
	wire dn_edge = freq_step_down_in & ~dn_d_r;
	wire step_ok = (mode_r == `MODE_FREE) || (mode_r == `MODE_LOCK); // R12
	wire reg_cmd = avs_write_in && !bus_done_r && avs_address_in[3:0] == `REG_STEP_CMD;
	wire do_up = step_ok && (up_edge || (reg_cmd && avs_writedata_in[0]));
	wire do_dn = step_ok && (dn_edge || (reg_cmd && avs_writedata_in[1]));

	// ----------------------------------------
	// Avalon-MM slave, one wait state
	// ----------------------------------------
	// Done flag blocks a second take while the master still holds.
	// Writes land on the taking edge; read data stands with the answer.
	always @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			ctrl_r <= `CTRL_RESET; // R13 pins default
			prio_r <= 8'he4;
			win_r <= {HIST_AW{1'b1}};
			dly_r <= {HIST_AW{1'b0}};
			step_word_r <= 32'h0000_0000;
			step_mask_r <= {NUM_DIV{1'b1}};
			div_r <= {(NUM_DIV*32){1'b0}};
			up_d_r <= 1'b0;
			dn_d_r <= 1'b0;
			bus_done_r <= 1'b0;
			avs_readdata_out <= 32'h0000_0000;
			avs_waitrequest_out <= 1'b1;
		end else begin
			up_d_r <= freq_step_up_in;
			dn_d_r <= freq_step_down_in;
			bus_done_r <= (avs_read_in || avs_write_in) && !bus_done_r;
			avs_waitrequest_out <= !((avs_read_in || avs_write_in) && !bus_done_r);
			if (avs_write_in && !bus_done_r) begin
				case (avs_address_in[3:0])
					`REG_CTRL:      ctrl_r <= avs_writedata_in; // R7 R8 R9 R19 R21
					`REG_PRIO:      prio_r <= avs_writedata_in[7:0];
					`REG_HOLD_WIN:  begin
						win_r <= avs_writedata_in[HIST_AW-1:0];
						dly_r <= avs_writedata_in[16+:HIST_AW];
					end
					`REG_STEP_WORD: step_word_r <= avs_writedata_in;
					`REG_STEP_CMD:  step_mask_r <= avs_writedata_in[8+:NUM_DIV]; // R11
					default: ;
				endcase
			end
			// Step applied to the masked dividers
			for (i = 0; i < NUM_DIV; i = i + 1) begin
				if (step_mask_r[i] && do_up && !do_dn)
					div_r[32*i+:32] <= div_r[32*i+:32] + step_word_r; // R10
				else if (step_mask_r[i] && do_dn && !do_up)
					div_r[32*i+:32] <= div_r[32*i+:32] - step_word_r; // R10
			end
			if (avs_read_in && !bus_done_r) begin
				case (avs_address_in[3:0])
					`REG_CTRL:      avs_readdata_out <= ctrl_r;
					`REG_PRIO:      avs_readdata_out <= {24'h000000, prio_r};
					`REG_HOLD_WIN:  avs_readdata_out <= {{(16-HIST_AW){1'b0}}, dly_r,
					                                     {(16-HIST_AW){1'b0}}, win_r};
					`REG_STEP_WORD: avs_readdata_out <= step_word_r;
					`REG_STATUS:    avs_readdata_out <= {16'h0000, 4'h0, usable,
					                  1'b0, ~loss_of_lock_flag_out, act_r, mode_r}; // R25 R1
					`REG_HOLD_FREQ: avs_readdata_out <= hold_freq_r;
					default:
						if (avs_address_in[3:0] >= `REG_NCO_0 &&
						    avs_address_in[3:0] < `REG_NCO_0 + NUM_DIV)
							avs_readdata_out <= div_r[32*(avs_address_in[3:0]-`REG_NCO_0)+:32];
						else
							avs_readdata_out <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Registered outputs
	// ----------------------------------------
	// Every output lags its source state by one clock.
	always @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			active_input_out <= 4'h0;
			mode_out <= `MODE_FREE;
			loss_of_lock_flag_out <= 1'b1;
			fast_bw_out <= 1'b0;
			hitless_out <= 1'b0;
			loop_freq_out <= 32'h0000_0000;
			loop_freq_hold_out <= 1'b0;
			ext_ref_out <= 1'b0;
			xtal_cap_en_out <= 1'b1;
			ref_div_out <= 3'h0;
			ref_trim_out <= 10'h000;
			ref_trim_neg_out <= 1'b0;
			divider_freq_out <= {(NUM_DIV*32){1'b0}};
		end else begin
			active_input_out <= act_ok_r ? (4'h1 << act_r) : 4'h0; // R25
			mode_out <= mode_r; // R25
			loss_of_lock_flag_out <= (mode_r != `MODE_LOCK); // R1 R20
			fast_bw_out <= ctrl_r[`CTRL_FASTLOCK] && (mode_r == `MODE_ACQ); // R24 R6
			hitless_out <= ctrl_r[`CTRL_HITLESS]; // R19
			loop_freq_out <= hold_freq_r; // R5
			loop_freq_hold_out <= (mode_r == `MODE_HOLD); // R5
			ext_ref_out <= ctrl_r[`CTRL_EXT_REF]; // R7
			xtal_cap_en_out <= ~ctrl_r[`CTRL_EXT_REF]; // R7
			ref_div_out <= ctrl_r[`CTRL_PREF_HI:`CTRL_PREF_LO]; // R8
			ref_trim_out <= (ctrl_r[`CTRL_TRIM_HI-1:`CTRL_TRIM_LO] > `TRIM_MAX_PPM) ?
			                 `TRIM_MAX_PPM : {1'b0, ctrl_r[`CTRL_TRIM_HI-1:`CTRL_TRIM_LO]}; // R9
			ref_trim_neg_out <= ctrl_r[`CTRL_TRIM_HI]; // R9
			divider_freq_out <= div_r; // R10
		end
	end

endmodule // input_select_holdover_ctrl

`default_nettype wire
